// File: logic/ssc_device.sv
// device end: serial command decode, config registers, diagnostics
`default_nettype none
// Notes on behaviour
// - messages are sixteen bits, msb first
// - host toggles watchdog bit every message
// - bits 14:13 pick the output
// - bits 12:10 pick the register
// - host sends bit 9 as zero
// - bits 8:0 are the payload
// - chained messages allowed in multiples of sixteen
// - odd length transfers change nothing
// - register code map, globals need select zero
// - supply loss clears registers and faults
// - logic supply fail with enable clears registers
// - no logic supply: direct inputs, zero settings
// - battery loss keeps config, flags undervoltage
// - off open load latched, read clears
// - off open load disable suppresses detection
// - on open load flags, fault pin untouched
// - led check periodic, fully on only
// - on open load latched, disable skips
// - prewarning latched in normal mode
// - fail safe disables current sense
// - status select picks returned word
module ssc_device #(
  parameter int LED_THRESHOLD_SELECT_CYCLES = ssc_pkg::LED_THRESHOLD_SELECT_CYCLES
) (
  input  wire logic            mclk,
  input  wire logic            arst_n,
  input  wire logic            clk_en,
  ssc_link_if.dev              link,
  input  wire logic [3:0]      direct_in,
  input  wire logic [3:0]      off_open_load_det,
  input  wire logic [3:0]      on_open_load_det,
  input  wire logic            temp_warn_det,
  input  wire logic            vpwr_uv_det,
  input  wire logic            vdd_fail,
  input  wire logic            supply_por,
  input  wire logic            fail_safe,
  output logic [3:0]           switch_outputs,
  output logic [3:0]           off_state_open_load_flag,
  output logic [3:0]           on_state_open_load_flag,
  output logic                 temperature_prewarning_flag,
  output logic                 undervoltage_flag,
  output logic                 fault_status_pin_n,
  output logic                 current_sense_enable,
  output logic [1:0]           sense_channel_select,
  output logic                 sense_ratio_select,
  output logic                 watchdog_toggle_bit
);
  // ---------------------------------------------------------------
  // pin synchronisers: [0] sclk, [1] cs_n, [2] mosi
  // ---------------------------------------------------------------
  logic [2:0] s1_ff, s2_ff, s3_ff, filt_ff;
  wire  [2:0] agree    = ~(s2_ff ^ s3_ff);
  wire  [2:0] nxt_filt = (agree & s3_ff) | (~agree & filt_ff);
  wire        sclk_rise = nxt_filt[0] & ~filt_ff[0];
  wire        cs_fall   = ~nxt_filt[1] & filt_ff[1];
  wire        cs_rise   = nxt_filt[1] & ~filt_ff[1];
  wire        selected  = ~filt_ff[1];

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s1_ff   <= ssc_pkg::LINK_IDLE;
      s2_ff   <= ssc_pkg::LINK_IDLE;
      s3_ff   <= ssc_pkg::LINK_IDLE;
      filt_ff <= ssc_pkg::LINK_IDLE;
    end else if (clk_en) begin
      s1_ff   <= {link.mosi, link.cs_n, link.sclk};
      s2_ff   <= s1_ff;
      s3_ff   <= s2_ff;
      filt_ff <= nxt_filt;
    end
  end

  // ---------------------------------------------------------------
  // shift register and bit count
  // ---------------------------------------------------------------
  ssc_pkg::ssc_word_t shift_ff;
  ssc_pkg::ssc_word_t status_word;
  logic [3:0]         bitcnt_ff;
  logic               full_ff;

  // a cut-off transfer leaves bitcnt off zero and is dropped
  wire commit = cs_rise & full_ff & (bitcnt_ff == ssc_pkg::BIT_FIRST);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      shift_ff  <= '0;
      bitcnt_ff <= '0;
      full_ff   <= 1'b0;
    end else if (clk_en) begin
      if (cs_fall) begin
        shift_ff  <= status_word;
        bitcnt_ff <= ssc_pkg::BIT_FIRST;
        full_ff   <= 1'b0;
      end else if (sclk_rise && selected) begin
        // msb leaves first; incoming bits trail for daisy chains
        shift_ff  <= {shift_ff[ssc_pkg::MSG_BITS-2:0], nxt_filt[2]};
        bitcnt_ff <= bitcnt_ff + 4'h1;
        if (bitcnt_ff == ssc_pkg::BIT_LAST) begin
          full_ff <= 1'b1;
        end
      end
    end
  end

  assign link.miso = shift_ff[ssc_pkg::WD_BIT];

  // ---------------------------------------------------------------
  // decode (last message of a chain wins)
  // ---------------------------------------------------------------
  wire ssc_pkg::ssc_osel_t osel =
    shift_ff[ssc_pkg::OSEL_HI:ssc_pkg::OSEL_LO];
  wire ssc_pkg::ssc_code_t code =
    shift_ff[ssc_pkg::CODE_HI:ssc_pkg::CODE_LO];
  wire ssc_pkg::ssc_pay_t pay = shift_ff[ssc_pkg::PAY_HI:0];
  wire glob_ok  = (osel == ssc_pkg::OSEL_GLOBAL);
  wire wr_stat  = commit & (code == ssc_pkg::CODE_STATUS);
  wire wr_duty  = commit & (code == ssc_pkg::CODE_DUTY);
  wire wr_sw    = commit & (code == ssc_pkg::CODE_SWITCH);
  wire wr_flt   = commit & (code == ssc_pkg::CODE_FAULT);
  wire wr_ocp   = commit & (code == ssc_pkg::CODE_OCP);
  wire wr_gcr   = commit & (code == ssc_pkg::CODE_GLOBAL) & glob_ok;
  wire wr_cal   = commit & (code == ssc_pkg::CODE_CAL) & glob_ok;

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  ssc_pkg::ssc_pay_t duty_ff [ssc_pkg::N_OUT];
  ssc_pkg::ssc_pay_t sw_ff   [ssc_pkg::N_OUT];
  ssc_pkg::ssc_pay_t flt_ff  [ssc_pkg::N_OUT];
  ssc_pkg::ssc_pay_t ocp_ff  [ssc_pkg::N_OUT];
  ssc_pkg::ssc_pay_t gcr_ff, cal_ff;
  logic [ssc_pkg::STAT_SEL_W-1:0] stat_sel_ff;

  wire reg_clear = supply_por
                 | (vdd_fail & gcr_ff[ssc_pkg::GCR_VDDFAIL_EN]);

  // vpwr_uv_det does not reach this block: config survives it
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < ssc_pkg::N_OUT; i++) begin
        duty_ff[i] <= ssc_pkg::REG_RESET;
        sw_ff[i]   <= ssc_pkg::REG_RESET;
        flt_ff[i]  <= ssc_pkg::REG_RESET;
        ocp_ff[i]  <= ssc_pkg::REG_RESET;
      end
      gcr_ff      <= ssc_pkg::REG_RESET;
      cal_ff      <= ssc_pkg::REG_RESET;
      stat_sel_ff <= '0;
    end else if (clk_en) begin
      if (reg_clear) begin
        for (int i = 0; i < ssc_pkg::N_OUT; i++) begin
          duty_ff[i] <= ssc_pkg::REG_RESET;
          sw_ff[i]   <= ssc_pkg::REG_RESET;
          flt_ff[i]  <= ssc_pkg::REG_RESET;
          ocp_ff[i]  <= ssc_pkg::REG_RESET;
        end
        gcr_ff      <= ssc_pkg::REG_RESET;
        cal_ff      <= ssc_pkg::REG_RESET;
        stat_sel_ff <= '0;
      end else begin
        if (wr_duty) duty_ff[osel] <= pay;
        if (wr_sw)   sw_ff[osel]   <= pay;
        if (wr_flt)  flt_ff[osel]  <= pay;
        if (wr_ocp)  ocp_ff[osel]  <= pay;
        if (wr_gcr)  gcr_ff        <= pay;
        if (wr_cal)  cal_ff        <= pay;
        if (wr_stat) stat_sel_ff   <= pay[ssc_pkg::STAT_SEL_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs and open-load checks (zero settings without vdd)
  // ---------------------------------------------------------------
  wire        vdd_ok = ~vdd_fail;
  logic [3:0] sw_on, det_off, det_on_bulb, led_arm;
  logic [ssc_pkg::LED_THRESHOLD_SELECT_CNT_W-1:0] on_cnt_ff [ssc_pkg::N_OUT];
  logic [3:0] led_tick;
  localparam logic [ssc_pkg::LED_THRESHOLD_SELECT_CNT_W-1:0] LED_LAST =
    ssc_pkg::LED_THRESHOLD_SELECT_CNT_W'(LED_THRESHOLD_SELECT_CYCLES - 1);

  for (genvar g = 0; g < ssc_pkg::N_OUT; g++) begin : g_out
    wire ssc_pkg::ssc_pay_t d = vdd_ok ? duty_ff[g] : ssc_pkg::REG_RESET;
    wire ssc_pkg::ssc_pay_t s = vdd_ok ? sw_ff[g]   : ssc_pkg::REG_RESET;
    wire ssc_pkg::ssc_pay_t f = vdd_ok ? flt_ff[g]  : ssc_pkg::REG_RESET;
    assign sw_on[g] = d[ssc_pkg::DUTY_ON_BIT]
                    | (direct_in[g] & ~s[ssc_pkg::SW_DIR_DIS_BIT]);
    assign det_off[g] = ~sw_on[g] & off_open_load_det[g]
                      & ~f[ssc_pkg::FLT_OFF_OPEN_LOAD_DISABLE];
    assign det_on_bulb[g] = sw_on[g] & on_open_load_det[g]
                      & ~f[ssc_pkg::FLT_ON_OPEN_LOAD_DISABLE] & ~f[ssc_pkg::FLT_LED_THRESHOLD_SELECT_EN];
    assign led_arm[g] = sw_on[g] & f[ssc_pkg::FLT_LED_THRESHOLD_SELECT_EN]
                      & ~f[ssc_pkg::FLT_ON_OPEN_LOAD_DISABLE]
                      & (d[6:0] == ssc_pkg::DUTY_FULL);
    assign led_tick[g] = led_arm[g] & (on_cnt_ff[g] == LED_LAST)
                       & on_open_load_det[g];
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < ssc_pkg::N_OUT; i++) on_cnt_ff[i] <= '0;
    end else if (clk_en) begin
      // restarts on any off or non-full duty, so a full period is needed
      for (int i = 0; i < ssc_pkg::N_OUT; i++) begin
        if (!led_arm[i] || on_cnt_ff[i] == LED_LAST) on_cnt_ff[i] <= '0;
        else on_cnt_ff[i] <= on_cnt_ff[i] + 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // latched diagnostics: set beats read-clear
  // ---------------------------------------------------------------
  wire [3:0] set_on   = det_on_bulb | led_tick;
  wire       set_temp = temp_warn_det & ~fail_safe;
  wire [3:0] clr_off  = {4{commit}} & ~off_open_load_det;
  wire [3:0] clr_on   = {4{commit}} & ~on_open_load_det;
  wire       clr_uv   = commit & ~vpwr_uv_det;
  wire ssc_pkg::ssc_pay_t flt_sel =
    flt_ff[gcr_ff[ssc_pkg::GCR_SENSE_HI:ssc_pkg::GCR_SENSE_LO]];

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      off_state_open_load_flag    <= '0;
      on_state_open_load_flag     <= '0;
      temperature_prewarning_flag <= 1'b0;
      undervoltage_flag           <= 1'b0;
    end else if (clk_en) begin
      if (supply_por) begin
        off_state_open_load_flag    <= '0;
        on_state_open_load_flag     <= '0;
        temperature_prewarning_flag <= 1'b0;
        undervoltage_flag           <= 1'b0;
      end else begin
        off_state_open_load_flag <= det_off
          | (off_state_open_load_flag & ~clr_off);
        on_state_open_load_flag <= set_on
          | (on_state_open_load_flag & ~clr_on);
        temperature_prewarning_flag <= set_temp
          | (temperature_prewarning_flag & ~commit);
        undervoltage_flag <= vpwr_uv_det
          | (undervoltage_flag & ~clr_uv);
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      switch_outputs       <= '0;
      fault_status_pin_n   <= 1'b1;
      current_sense_enable <= 1'b0;
      sense_channel_select <= '0;
      sense_ratio_select   <= 1'b0;
      watchdog_toggle_bit  <= 1'b0;
    end else if (clk_en) begin
      switch_outputs     <= sw_on;
      // on-state open load deliberately kept off this pin
      fault_status_pin_n <= ~(|det_off | vpwr_uv_det);
      current_sense_enable <= gcr_ff[ssc_pkg::GCR_SENSE_EN] & vdd_ok
                            & ~fail_safe;
      sense_channel_select <= gcr_ff[ssc_pkg::GCR_SENSE_HI:ssc_pkg::GCR_SENSE_LO];
      sense_ratio_select   <= flt_sel[ssc_pkg::FLT_RATIO_HIGH] & vdd_ok;
      if (commit) watchdog_toggle_bit <= shift_ff[ssc_pkg::WD_BIT];
    end
  end

  // ---------------------------------------------------------------
  // returned word: sel[4:3] output, sel[2:0] register code
  // ---------------------------------------------------------------
  wire status_return_select_msb = stat_sel_ff[ssc_pkg::STAT_MSB];
  wire ssc_pkg::ssc_osel_t rd_out = {status_return_select_msb, stat_sel_ff[3]};
  wire ssc_pkg::ssc_code_t rd_code = stat_sel_ff[2:0];
  ssc_pkg::ssc_pay_t rd_pay;

  always_comb begin
    unique case (rd_code)
      ssc_pkg::CODE_DUTY:   rd_pay = duty_ff[rd_out];
      ssc_pkg::CODE_SWITCH: rd_pay = sw_ff[rd_out];
      ssc_pkg::CODE_FAULT:  rd_pay = flt_ff[rd_out];
      ssc_pkg::CODE_OCP:    rd_pay = ocp_ff[rd_out];
      ssc_pkg::CODE_GLOBAL: rd_pay = gcr_ff;
      ssc_pkg::CODE_CAL:    rd_pay = cal_ff;
      default: rd_pay = {undervoltage_flag, on_state_open_load_flag,
                         off_state_open_load_flag};
    endcase
  end
  assign status_word = {temperature_prewarning_flag, rd_out, rd_code,
                        1'b0, rd_pay};
endmodule : ssc_device
`default_nettype wire

// File: shared/ssc_pkg.sv
// shared constants, types and states of the serial command front end
`default_nettype none
package ssc_pkg;
  // ---------------------------------------------------------------
  // message layout
  // ---------------------------------------------------------------
  localparam int MSG_BITS   = 16;
  localparam int WD_BIT     = 15;
  localparam int OSEL_HI    = 14;
  localparam int OSEL_LO    = 13;
  localparam int CODE_HI    = 12;
  localparam int CODE_LO    = 10;
  localparam int UNUSED_BIT = 9;
  localparam int PAY_HI     = 8;
  localparam int N_OUT      = 4;

  typedef logic [15:0] ssc_word_t;
  typedef logic [8:0]  ssc_pay_t;
  typedef logic [2:0]  ssc_code_t;
  typedef logic [1:0]  ssc_osel_t;

  localparam ssc_code_t CODE_STATUS = 3'h0;
  localparam ssc_code_t CODE_DUTY   = 3'h1;
  localparam ssc_code_t CODE_SWITCH = 3'h2;
  localparam ssc_code_t CODE_FAULT  = 3'h3;
  localparam ssc_code_t CODE_OCP    = 3'h4;
  localparam ssc_code_t CODE_GLOBAL = 3'h5;
  localparam ssc_code_t CODE_CAL    = 3'h7;
  localparam ssc_osel_t OSEL_GLOBAL = 2'h0;
  localparam ssc_pay_t  REG_RESET   = 9'h000;
  localparam logic [3:0] BIT_LAST   = 4'hf;
  localparam logic [3:0] BIT_FIRST  = 4'h0;

  // ---------------------------------------------------------------
  // payload fields
  // ---------------------------------------------------------------
  localparam int DUTY_ON_BIT     = 7;
  localparam logic [6:0] DUTY_FULL = 7'h7f;
  localparam int SW_DIR_DIS_BIT  = 5;
  localparam int FLT_ON_OPEN_LOAD_DISABLE    = 3;
  localparam int FLT_OFF_OPEN_LOAD_DISABLE   = 2;
  localparam int FLT_LED_THRESHOLD_SELECT_EN    = 1;
  localparam int FLT_RATIO_HIGH  = 0;
  localparam int GCR_VDDFAIL_EN  = 8;
  localparam int GCR_SENSE_EN    = 4;
  localparam int GCR_SENSE_HI    = 3;
  localparam int GCR_SENSE_LO    = 2;
  localparam int STAT_SEL_W      = 5;
  localparam int STAT_MSB        = 4;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ         = 20;
  localparam int LED_THRESHOLD_SELECT_PERIOD_US = 1000;
  localparam int LED_THRESHOLD_SELECT_CYCLES    = LED_THRESHOLD_SELECT_PERIOD_US * CLK_MHZ;
  localparam int LED_THRESHOLD_SELECT_CNT_W     = 24;
  localparam logic [3:0] HALF_CYCLES = 4'ha;
  localparam logic [3:0] GAP_CYCLES  = 4'ha;
  localparam logic [2:0] LINK_IDLE   = 3'h2;

  typedef enum logic [4:0] {
    HST_IDLE  = 5'h01,
    HST_LOW   = 5'h02,
    HST_HIGH  = 5'h04,
    HST_CHAIN = 5'h08,
    HST_GAP   = 5'h10
  } ssc_hst_t;
endpackage : ssc_pkg
`default_nettype wire

// File: shared/ssc_link_if.sv
// serial link between host controller and switch command front end
`default_nettype none
interface ssc_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  modport dev  (input sclk, input cs_n, input mosi, output miso);
  modport host (output sclk, output cs_n, output mosi, input miso);
endinterface : ssc_link_if
`default_nettype wire

// File: logic/ssc_host.sv
// host end: serial master that frames, clocks and chains messages
`default_nettype none
module ssc_host (
  input  wire logic               mclk,
  input  wire logic               arst_n,
  input  wire logic               clk_en,
  ssc_link_if.host                link,
  input  wire logic               cmd_valid,
  output logic                    cmd_ready,
  input  wire ssc_pkg::ssc_word_t cmd_word,
  input  wire logic               cmd_chain,
  output logic                    resp_valid,
  output ssc_pkg::ssc_word_t      resp_word,
  output logic                    busy
);
  // ---------------------------------------------------------------
  // miso synchroniser
  // ---------------------------------------------------------------
  logic m1_ff, m2_ff, m3_ff, mf_ff;
  wire  nxt_mf = (m2_ff == m3_ff) ? m3_ff : mf_ff;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      m1_ff <= 1'b0;
      m2_ff <= 1'b0;
      m3_ff <= 1'b0;
      mf_ff <= 1'b0;
    end else if (clk_en) begin
      m1_ff <= link.miso;
      m2_ff <= m1_ff;
      m3_ff <= m2_ff;
      mf_ff <= nxt_mf;
    end
  end

  // ---------------------------------------------------------------
  // framing state machine
  // ---------------------------------------------------------------
  ssc_pkg::ssc_hst_t  state_ff;
  ssc_pkg::ssc_word_t tx_ff, rx_ff;
  logic [3:0]         cnt_ff, bit_ff;
  logic               sclk_ff, cs_n_ff, wd_ff, chain_ff;

  wire take     = cmd_valid & cmd_ready;
  wire half_end = (cnt_ff == ssc_pkg::HALF_CYCLES - 4'h1);
  wire gap_end  = (cnt_ff == ssc_pkg::GAP_CYCLES - 4'h1);
  wire last_bit = (bit_ff == ssc_pkg::BIT_LAST);
  wire ssc_pkg::ssc_word_t framed = {wd_ff,
    cmd_word[ssc_pkg::OSEL_HI:ssc_pkg::CODE_LO], 1'b0,
    cmd_word[ssc_pkg::PAY_HI:0]};

  assign cmd_ready = (state_ff == ssc_pkg::HST_IDLE)
                   | (state_ff == ssc_pkg::HST_CHAIN);
  assign busy      = (state_ff != ssc_pkg::HST_IDLE);
  assign link.sclk = sclk_ff;
  assign link.cs_n = cs_n_ff;
  assign link.mosi = tx_ff[ssc_pkg::WD_BIT];

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff   <= ssc_pkg::HST_IDLE;
      tx_ff      <= '0;
      rx_ff      <= '0;
      cnt_ff     <= '0;
      bit_ff     <= '0;
      sclk_ff    <= 1'b0;
      cs_n_ff    <= 1'b1;
      wd_ff      <= 1'b0;
      chain_ff   <= 1'b0;
      resp_valid <= 1'b0;
      resp_word  <= '0;
    end else if (clk_en) begin
      resp_valid <= 1'b0;
      cnt_ff     <= cnt_ff + 4'h1;
      unique case (state_ff)
        ssc_pkg::HST_IDLE, ssc_pkg::HST_CHAIN: begin
          if (take) begin
            tx_ff    <= framed;
            wd_ff    <= ~wd_ff;
            chain_ff <= cmd_chain;
            cs_n_ff  <= 1'b0;
            cnt_ff   <= '0;
            bit_ff   <= ssc_pkg::BIT_FIRST;
            state_ff <= ssc_pkg::HST_LOW;
          end
        end
        ssc_pkg::HST_LOW: begin
          if (half_end) begin
            rx_ff    <= {rx_ff[ssc_pkg::MSG_BITS-2:0], mf_ff};
            sclk_ff  <= 1'b1;
            cnt_ff   <= '0;
            state_ff <= ssc_pkg::HST_HIGH;
          end
        end
        ssc_pkg::HST_HIGH: begin
          if (half_end) begin
            sclk_ff <= 1'b0;
            cnt_ff  <= '0;
            if (last_bit) begin
              // sixteen clocks per word, always whole words
              resp_valid <= 1'b1;
              resp_word  <= rx_ff;
              state_ff   <= chain_ff ? ssc_pkg::HST_CHAIN
                                     : ssc_pkg::HST_GAP;
            end else begin
              tx_ff    <= {tx_ff[ssc_pkg::MSG_BITS-2:0], 1'b0};
              bit_ff   <= bit_ff + 4'h1;
              state_ff <= ssc_pkg::HST_LOW;
            end
          end
        end
        ssc_pkg::HST_GAP: begin
          cs_n_ff <= 1'b1;
          if (gap_end) begin
            state_ff <= ssc_pkg::HST_IDLE;
          end
        end
      endcase
    end
  end
endmodule : ssc_host
`default_nettype wire

// File: sim/ssc_link_sva.sv
// wire-level checker for the serial command link
`default_nettype none
module ssc_link_sva (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       sclk_q_ff;
  logic       wd_ff;
  logic [3:0] bits_ff;
  logic [3:0] nxt_bits;
  wire        rise = sclk & ~sclk_q_ff;
  wire        wstart = rise & (bits_ff == 4'h0);
  // bit count wraps at sixteen, so zero at deselect means whole words
  assign nxt_bits = cs_n ? 4'h0 : bits_ff + {3'h0, rise};
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_q_ff <= 1'b0;
      bits_ff   <= 4'h0;
      // host sends zero in the first word, so start from one
      wd_ff     <= 1'b1;
    end else begin
      sclk_q_ff <= sclk;
      bits_ff   <= nxt_bits;
      wd_ff     <= wstart ? mosi : wd_ff;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  a_sclk_idle_low: assert property (cs_n |-> !sclk)
    else $error("serial clock high while deselected");
  a_mosi_hold: assert property (sclk |-> $stable(mosi))
    else $error("data moved while serial clock high");
  a_high_len: assert property ($rose(sclk) |-> sclk [*8])
    else $error("serial clock high phase too short");
  a_low_len: assert property ($fell(sclk) |-> !sclk [*8])
    else $error("serial clock low phase too short");
  a_select_setup: assert property ($fell(cs_n) |-> !sclk [*8])
    else $error("clock too soon after select");
  a_whole_words: assert property ($rose(cs_n) |-> bits_ff == 4'h0)
    else $error("frame not a multiple of sixteen bits");
  a_wd_toggles: assert property (wstart |-> mosi != wd_ff)
    else $error("watchdog bit did not toggle");
  a_unused_zero: assert property (rise && bits_ff == 4'h6 |-> !mosi)
    else $error("unused bit sent high");
  c_frame: cover property ($rose(cs_n));
  c_word: cover property (wstart && !cs_n);
  c_miso: cover property (!cs_n && miso);
endmodule : ssc_link_sva
`default_nettype wire

// File: sim/ssc_tb_top.sv
// bench: host and device ends joined over the serial link
`default_nettype none
module ssc_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic               mclk = 1'b0, arst_n = 1'b0, en = 1'b1, tg = 1'b0;
  logic               twd = 1'b0, uvd = 1'b0, vf = 1'b0, por = 1'b0;
  logic               fsf = 1'b0, cv = 1'b0, cch = 1'b0;
  logic [3:0]         din = 4'h0, offd = 4'h0, ond = 4'h0, sw, offf, onf;
  logic [1:0]         csel;
  logic               tf, uvf, fsn, cse, crat, wdo, crdy, rv, bsy;
  ssc_pkg::ssc_word_t cw = 16'h0000, rw, rx;
  int                 bad_count = 0, cmp_count = 0;
  ssc_link_if lk ();
  always #25 mclk = ~mclk;
  // short led check period keeps the run brief
  ssc_device #(.LED_THRESHOLD_SELECT_CYCLES(8)) i_ssc_device (.mclk(mclk),
    .arst_n(arst_n), .clk_en(en), .link(lk), .direct_in(din),
    .off_open_load_det(offd), .on_open_load_det(ond),
    .temp_warn_det(twd), .vpwr_uv_det(uvd), .vdd_fail(vf),
    .supply_por(por), .fail_safe(fsf), .switch_outputs(sw),
    .off_state_open_load_flag(offf), .on_state_open_load_flag(onf),
    .temperature_prewarning_flag(tf), .undervoltage_flag(uvf),
    .fault_status_pin_n(fsn), .current_sense_enable(cse),
    .sense_channel_select(csel), .sense_ratio_select(crat),
    .watchdog_toggle_bit(wdo));
  ssc_host i_ssc_host (.mclk(mclk), .arst_n(arst_n), .clk_en(en),
    .link(lk), .cmd_valid(cv), .cmd_ready(crdy), .cmd_word(cw),
    .cmd_chain(cch), .resp_valid(rv), .resp_word(rw), .busy(bsy));
  ssc_link_sva i_ssc_link_sva (.mclk(mclk), .arst_n(arst_n),
    .sclk(lk.sclk), .cs_n(lk.cs_n), .mosi(lk.mosi), .miso(lk.miso));
  task automatic chk_w(input ssc_pkg::ssc_word_t g, input ssc_pkg::ssc_word_t e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk_w
  task automatic chk_f(input logic [3:0] g, input logic [3:0] e);
    chk_w({12'h000, g}, {12'h000, e});
  endtask : chk_f
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask : tick
  task automatic wait_rdy();
    int n;
    n = 0;
    while (crdy !== 1'b1 && n < 2000) begin
      tick(1);
      n++;
    end
    if (n >= 2000) bad_count++;
  endtask : wait_rdy
  task automatic xfer(input ssc_pkg::ssc_word_t w, input logic ch);
    int n;
    wait_rdy();
    cv = 1'b1;
    cw = w;
    cch = ch;
    tick(1);
    cv = 1'b0;
    n = 0;
    while (rv !== 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
    if (n >= 400) bad_count++;
    rx = rw;
    tg = ~tg;
    if (!ch) wait_rdy();
  endtask : xfer
  function automatic ssc_pkg::ssc_word_t mk(input logic [1:0] o,
      input ssc_pkg::ssc_code_t c, input ssc_pkg::ssc_pay_t p);
    return {1'b0, o, c, 1'b0, p};
  endfunction : mk
  task automatic t_duty();
    xfer(mk(2'h2, ssc_pkg::CODE_DUTY, 9'h080), 1'b0);
    chk_f(sw, 4'h4);
    xfer(mk(2'h1, ssc_pkg::CODE_DUTY, 9'h080), 1'b0);
    chk_f(sw, 4'h6);
    xfer(mk(2'h2, ssc_pkg::CODE_DUTY, 9'h000), 1'b0);
    chk_f(sw, 4'h2);
    xfer(mk(2'h2, 3'h6, 9'h080), 1'b0);
    chk_f(sw, 4'h2);
    $display("t_duty done");
  endtask : t_duty
  task automatic t_glob();
    xfer(mk(2'h1, ssc_pkg::CODE_GLOBAL, 9'h01c), 1'b0);
    chk_f({1'b0, cse, csel}, 4'h0);
    xfer(mk(2'h0, ssc_pkg::CODE_GLOBAL, 9'h01c), 1'b0);
    chk_f({1'b0, cse, csel}, 4'h7);
    fsf = 1'b1;
    tick(3);
    chk_f({1'b0, cse, csel}, 4'h3);
    fsf = 1'b0;
    $display("t_glob done");
  endtask : t_glob
  task automatic t_chain();
    ssc_pkg::ssc_word_t w0;
    w0 = mk(2'h0, ssc_pkg::CODE_DUTY, 9'h080);
    w0[15] = tg;
    xfer(w0, 1'b1);
    xfer(mk(2'h1, ssc_pkg::CODE_DUTY, 9'h000), 1'b0);
    chk_w(rx, w0);
    chk_f(sw, 4'h0);
    chk_f({3'h0, wdo}, {3'h0, ~tg});
    $display("t_chain done");
  endtask : t_chain
  task automatic t_flags();
    offd = 4'h8;
    twd = 1'b1;
    tick(3);
    twd = 1'b0;
    tick(2);
    chk_f({offf[3], fsn, tf, uvf}, 4'ha);
    offd = 4'h0;
    xfer(mk(2'h0, ssc_pkg::CODE_STATUS, 9'h000), 1'b0);
    chk_f({offf[3], fsn, tf, uvf}, 4'h4);
    xfer(mk(2'h3, ssc_pkg::CODE_FAULT, 9'h004), 1'b0);
    offd = 4'h8;
    tick(3);
    chk_f(offf, 4'h0);
    offd = 4'h0;
    xfer(mk(2'h2, ssc_pkg::CODE_DUTY, 9'h080), 1'b0);
    ond = 4'h4;
    tick(3);
    ond = 4'h0;
    chk_f({onf[2], fsn, sw[2], 1'b0}, 4'he);
    $display("t_flags done");
  endtask : t_flags
  task automatic t_sup();
    uvd = 1'b1;
    tick(3);
    uvd = 1'b0;
    chk_f({uvf, onf[2], sw[2], 1'b0}, 4'he);
    xfer(mk(2'h0, ssc_pkg::CODE_GLOBAL, 9'h100), 1'b0);
    din = 4'h1;
    vf = 1'b1;
    tick(3);
    chk_f(sw, 4'h1);
    vf = 1'b0;
    din = 4'h0;
    tick(3);
    chk_f(sw, 4'h0);
    xfer(mk(2'h2, ssc_pkg::CODE_DUTY, 9'h080), 1'b0);
    por = 1'b1;
    tick(3);
    por = 1'b0;
    tick(2);
    chk_w({sw, offf, onf, tf, uvf, fsn, cse}, 16'h0002);
    $display("t_sup done");
  endtask : t_sup
  task automatic t_regs();
    logic [1:0] o;
    for (int i = 1; i < 8; i++) begin
      if (i == 6) continue;
      o = (i >= 5) ? 2'h0 : 2'h3;
      xfer(mk(o, 3'(i), 9'h15b), 1'b0);
      xfer(mk(2'h0, ssc_pkg::CODE_STATUS, {4'h0, o, 3'(i)}), 1'b0);
      xfer(mk(2'h0, 3'h6, 9'h000), 1'b0);
      chk_w(rx, {1'b0, o, 3'(i), 1'b0, 9'h15b});
    end
    $display("t_regs done");
  endtask : t_regs
  task automatic t_led();
    xfer(mk(2'h0, ssc_pkg::CODE_FAULT, 9'h002), 1'b0);
    xfer(mk(2'h0, ssc_pkg::CODE_DUTY, 9'h0fe), 1'b0);
    ond = 4'h1;
    tick(20);
    chk_f(onf, 4'h0);
    xfer(mk(2'h0, ssc_pkg::CODE_DUTY, 9'h0ff), 1'b0);
    tick(20);
    chk_f(onf, 4'h1);
    ond = 4'h0;
    $display("t_led done");
  endtask : t_led
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report
  initial begin
    #(60000 * 50);
    bad_count++;
    final_report();
  end
  initial begin
    tick(10);
    arst_n = 1'b1;
    tick(10);
    chk_w({sw, offf, onf, tf, uvf, fsn, cse}, 16'h0002);
    t_duty();
    t_glob();
    t_chain();
    t_flags();
    t_sup();
    t_regs();
    t_led();
    final_report();
  end
endmodule : ssc_tb_top
`default_nettype wire
